//--- verilog/io_expander_pkg.sv
// shared constants and types for the i2c io expander
package io_expander_pkg;
   localparam int PORT_WIDTH = 8;
   localparam logic [6:0] TARGET_ADDR_LOW = 7'h20;
   localparam logic [6:0] TARGET_ADDR_HIGH = 7'h21;
   localparam logic [1:0] CMD_INPUT = 2'h0;
   localparam logic [1:0] CMD_OUTPUT = 2'h1;
   localparam logic [1:0] CMD_POLARITY = 2'h2;
   localparam logic [1:0] CMD_CONFIG = 2'h3;
   localparam logic [7:0] OUTPUT_RESET = 8'hFF;
   localparam logic [7:0] POLARITY_RESET = 8'h00;
   localparam logic [7:0] CONFIG_RESET = 8'hFF;
   localparam logic [7:0] CMD_RESET = 8'h00;
   localparam logic [2:0] BIT_MSB = 3'h7;
   localparam logic [2:0] BIT_ZERO = 3'h0;
   localparam logic [1:0] EDGE_FLOPS = 2'h2;
   localparam int SYNC_STAGES = 2;
   // alert valid delay and read-clear delay, each at most 4 us
   localparam int CLK_MHZ = 100;
   localparam int ALERT_VALID_NS = 4000;
   localparam int ALERT_VALID_CYC = ALERT_VALID_NS * CLK_MHZ / 1000;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_ADDR_ACK = 3'b011,
      ST_RX = 3'b010,
      ST_RX_ACK = 3'b110,
      ST_TX = 3'b111,
      ST_TX_ACK = 3'b101,
      ST_IGNORE = 3'b100
   } bus_state_t;
endpackage

//--- verilog/bit_sync_if.sv
// interface carrying raw and synchronised bits to the synchroniser
`timescale 1ns/1ps
`default_nettype none
interface bit_sync_if #(parameter int W = 1);
   logic [W-1:0] raw;
   logic [W-1:0] sync;
   modport owner (output raw, input sync);
   modport stage (input raw, output sync);
endinterface
`default_nettype wire

//--- verilog/bit_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module bit_sync
   import io_expander_pkg::*;
#(
   parameter int W = 1
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // bits
   bit_sync_if.stage sig
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;

   // first flop feeds only the second
   always_comb
   begin
      meta_d = sig.raw;
      sync_d = meta_q;
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sig.sync = sync_q;
endmodule
`default_nettype wire

//--- verilog/i2c_io_expander_irq.sv
// eight-bit i2c io expander core with change alert
// Summary of operation
// - four byte registers: direction, input, output latch, polarity; one bit per pin
// - after reset every pin is an input
// - input register read value is inverted where polarity bit is set
// - all four registers readable over the serial bus
// - low external reset restores defaults and bus state machine
// - alert active while any input pin differs from captured input value
// - input edges raise alert, valid within the alert valid delay
// - alert clears when pin returns or when the port is read
// - read clearing happens at the ack or nack bit after scl rises
// - changes during the ack/nack pulse may give lost or short alert
// - after clearing, later input changes raise the alert again
// - traffic to other targets leaves alert logic alone
// - output pins never raise the alert
// - output to input switch may give a spurious alert, not suppressed
// - alert output is open drain, active low, pulls low only
// - input pin drivers off; output pins drive the latch bit
// - power-on reset initialises registers and bus state machine
// - after reset the device is always ready for bus requests
// - one address-select pin chooses between two target addresses
// - address 0x20 with select low, 0x21 with select high
// - last address bit: one reads, zero writes
// - command byte taken only as first byte of a write, then stored
// - direction bit one is input, zero is output
`timescale 1ns/1ps
`default_nettype none
module i2c_io_expander_irq
   import io_expander_pkg::*;
#(
   parameter int WIDTH = PORT_WIDTH
)
(
   // clock and resets
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ext_reset_n,
   // serial bus
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // address select
   input wire logic addr_sel,
   // expander pins
   input wire logic [WIDTH-1:0] expander_pin_bus_i,
   output logic [WIDTH-1:0] expander_pin_bus_o,
   output logic [WIDTH-1:0] expander_pin_bus_oe,
   // change alert, open drain
   output logic alert_n_o,
   output logic alert_n_oe
);
   localparam int SW = 3 + WIDTH;

   bit_sync_if #(.W(SW)) sy ();
   logic core_rst;
   logic rst_meta_q;
   logic rst_sync_q;

   // external reset synchronised on release, asserts at once
   always_ff @(posedge core_clk or posedge rst or negedge ext_reset_n)
   begin
      if (rst || !ext_reset_n)
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= 1'b1;
      end
      else
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= rst_meta_q;
      end
   end
   assign core_rst = rst_sync_q;

   assign sy.raw = {scl_i, sda_i, addr_sel, expander_pin_bus_i};

   bit_sync #(.W(SW)) u_sync (
      .core_clk(core_clk),
      .rst(core_rst),
      .sig(sy.stage)
   );

   logic scl_s;
   logic sda_s;
   logic sel_s;
   logic [WIDTH-1:0] pin_s;
   assign {scl_s, sda_s, sel_s, pin_s} = sy.sync;

   // edge detection on the synchronised bus lines
   logic scl_q;
   logic sda_q;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   assign scl_rise = scl_s && !scl_q;
   assign scl_fall = !scl_s && scl_q;
   assign start_cond = scl_s && scl_q && sda_q && !sda_s;
   assign stop_cond = scl_s && scl_q && !sda_q && sda_s;

   // bus state
   bus_state_t state_q;
   bus_state_t state_d;
   logic [2:0] bit_q;
   logic [2:0] bit_d;
   logic [7:0] shift_q;
   logic [7:0] shift_d;
   logic rd_q;
   logic rd_d;
   logic first_q;
   logic first_d;
   logic sda_drv_q;
   logic sda_drv_d;
   logic [7:0] cmd_q;
   logic [7:0] cmd_d;
   logic [WIDTH-1:0] out_q;
   logic [WIDTH-1:0] out_d;
   logic [WIDTH-1:0] pol_q;
   logic [WIDTH-1:0] pol_d;
   logic [WIDTH-1:0] cfg_q;
   logic [WIDTH-1:0] cfg_d;
   logic [WIDTH-1:0] in_q;
   logic [WIDTH-1:0] in_d;
   logic read_clear;
   logic [6:0] my_addr;

   // register select decode, used by the read mux only; the write path decodes cmd_q itself
   function automatic logic [7:0] reg_read(input logic [1:0] sel,
                                          input logic [WIDTH-1:0] inp,
                                          input logic [WIDTH-1:0] outp,
                                          input logic [WIDTH-1:0] pol,
                                          input logic [WIDTH-1:0] cfg);
      logic [7:0] r;
      r = '0;
      unique case (sel)
         CMD_INPUT: r[WIDTH-1:0] = inp ^ pol;
         CMD_OUTPUT: r[WIDTH-1:0] = outp;
         CMD_POLARITY: r[WIDTH-1:0] = pol;
         CMD_CONFIG: r[WIDTH-1:0] = cfg;
      endcase
      return r;
   endfunction

   assign my_addr = sel_s ? TARGET_ADDR_HIGH : TARGET_ADDR_LOW;

   always_comb
   begin
      state_d = state_q;
      bit_d = bit_q;
      shift_d = shift_q;
      rd_d = rd_q;
      first_d = first_q;
      sda_drv_d = sda_drv_q;
      cmd_d = cmd_q;
      out_d = out_q;
      pol_d = pol_q;
      cfg_d = cfg_q;
      read_clear = 1'b0;
      // start or restart wins from any state; stop returns to idle
      if (start_cond)
      begin
         state_d = ST_ADDR;
         bit_d = BIT_MSB;
         sda_drv_d = 1'b0;
      end
      else if (stop_cond)
      begin
         state_d = ST_IDLE;
         sda_drv_d = 1'b0;
      end
      else
      begin
         unique case (state_q)
            ST_IDLE, ST_IGNORE:
               sda_drv_d = 1'b0;
            ST_ADDR:
               if (scl_rise)
               begin
                  shift_d = {shift_q[6:0], sda_s};
                  if (bit_q == BIT_ZERO)
                     state_d = ST_ADDR_ACK;
                  else
                     bit_d = bit_q - 3'h1;
               end
            ST_ADDR_ACK:
               if (scl_fall)
               begin
                  if (shift_q[7:1] == my_addr && !sda_drv_q)
                  begin
                     sda_drv_d = 1'b1;
                     rd_d = shift_q[0];
                  end
                  else if (sda_drv_q)
                  begin
                     sda_drv_d = 1'b0;
                     bit_d = BIT_MSB;
                     first_d = !rd_q;
                     if (rd_q)
                     begin
                        state_d = ST_TX;
                        shift_d = reg_read(cmd_q[1:0], pin_s, out_q, pol_q, cfg_q);
                        sda_drv_d = !shift_d[7];
                     end
                     else
                        state_d = ST_RX;
                  end
                  else
                     state_d = ST_IGNORE;
               end
            ST_RX:
               if (scl_rise)
               begin
                  shift_d = {shift_q[6:0], sda_s};
                  if (bit_q == BIT_ZERO)
                     state_d = ST_RX_ACK;
                  else
                     bit_d = bit_q - 3'h1;
               end
            ST_RX_ACK:
               if (scl_fall)
               begin
                  if (!sda_drv_q)
                  begin
                     sda_drv_d = 1'b1;
                     if (first_q)
                        cmd_d = shift_q;
                     else
                     begin
                        unique case (cmd_q[1:0])
                           CMD_OUTPUT: out_d = shift_q[WIDTH-1:0];
                           CMD_POLARITY: pol_d = shift_q[WIDTH-1:0];
                           CMD_CONFIG: cfg_d = shift_q[WIDTH-1:0];
                           CMD_INPUT: ;
                        endcase
                     end
                  end
                  else
                  begin
                     sda_drv_d = 1'b0;
                     first_d = 1'b0;
                     bit_d = BIT_MSB;
                     state_d = ST_RX;
                  end
               end
            ST_TX:
               if (scl_fall)
               begin
                  if (bit_q == BIT_ZERO)
                  begin
                     state_d = ST_TX_ACK;
                     sda_drv_d = 1'b0;
                  end
                  else
                  begin
                     bit_d = bit_q - 3'h1;
                     shift_d = {shift_q[6:0], 1'b0};
                     sda_drv_d = !shift_d[7];
                  end
               end
            ST_TX_ACK:
               if (scl_rise)
               begin
                  // clear on the ack/nack bit after scl rises
                  read_clear = (cmd_q[1:0] == CMD_INPUT);
                  if (sda_s)
                     state_d = ST_IGNORE;
                  else
                  begin
                     // next byte's msb goes out at the falling edge ending the ack
                     bit_d = BIT_MSB;
                     shift_d = reg_read(cmd_q[1:0], pin_s, out_q, pol_q, cfg_q);
                  end
               end
               else if (scl_fall && bit_q == BIT_MSB)
               begin
                  state_d = ST_TX;
                  sda_drv_d = !shift_q[7];
               end
            default:
               state_d = ST_IDLE;
         endcase
      end
   end

   // input register: capture at read, and after reset once pin sync settles
   localparam logic [1:0] INIT_CYCLES = 2'(SYNC_STAGES + 1);
   logic [1:0] init_q;
   logic [1:0] init_d;
   always_comb
   begin
      in_d = in_q;
      init_d = init_q;
      if (|init_q)
         init_d = init_q - 2'h1;
      if (|init_q || read_clear)
         in_d = pin_s;
   end

   // alert: mismatch on input-configured pins only
   logic mismatch;
   logic alert_q;
   logic alert_d;
   assign mismatch = |((pin_s ^ in_q) & cfg_q);
   always_comb
   begin
      alert_d = mismatch && !read_clear && !(|init_q);
   end

   always_ff @(posedge core_clk or posedge core_rst)
   begin
      if (core_rst)
      begin
         state_q <= ST_IDLE;
         bit_q <= BIT_MSB;
         shift_q <= '0;
         rd_q <= 1'b0;
         first_q <= 1'b0;
         sda_drv_q <= 1'b0;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         cmd_q <= CMD_RESET;
         out_q <= OUTPUT_RESET[WIDTH-1:0];
         pol_q <= POLARITY_RESET[WIDTH-1:0];
         cfg_q <= CONFIG_RESET[WIDTH-1:0];
         in_q <= '0;
         init_q <= INIT_CYCLES;
         alert_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         bit_q <= bit_d;
         shift_q <= shift_d;
         rd_q <= rd_d;
         first_q <= first_d;
         sda_drv_q <= sda_drv_d;
         scl_q <= scl_s;
         sda_q <= sda_s;
         cmd_q <= cmd_d;
         out_q <= out_d;
         pol_q <= pol_d;
         cfg_q <= cfg_d;
         in_q <= in_d;
         init_q <= init_d;
         alert_q <= alert_d;
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe = sda_drv_q;
   // input pins tri-stated, outputs drive latch value
   assign expander_pin_bus_o = out_q;
   assign expander_pin_bus_oe = ~cfg_q;
   // open drain alert only pulls low
   assign alert_n_o = 1'b0;
   assign alert_n_oe = alert_q;
endmodule
`default_nettype wire

//--- testbench/io_expander_properties.sv
// concurrent checks on the io expander top-level ports
`timescale 1ns/1ps
`default_nettype none
module io_expander_properties #(
   parameter int WIDTH = 8
)
(
   // clock and resets
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ext_reset_n,
   // serial bus
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   // pins and alert
   input wire logic [WIDTH-1:0] expander_pin_bus_i,
   input wire logic [WIDTH-1:0] expander_pin_bus_o,
   input wire logic [WIDTH-1:0] expander_pin_bus_oe,
   input wire logic alert_n_o,
   input wire logic alert_n_oe
);
   logic [WIDTH-1:0] pin;
   logic [WIDTH-1:0] drv;
   logic ins;
   logic dflt;
   assign pin = expander_pin_bus_i;
   assign drv = expander_pin_bus_oe;
   // quiet bus and all pins inputs: nothing but a pin edge can move the alert
   assign ins = drv == '0 && scl_i;
   assign dflt = drv == '0 && expander_pin_bus_o == '1 && !alert_n_oe && !sda_oe;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (rst);
   a_drain_only: assert property (!alert_n_o && !sda_o)
      else $error("open drain output driven high");
   a_por_dflt: assert property ($fell(rst) |-> dflt [*2])
      else $error("outputs off default after power-on reset");
   a_ext_dflt: assert property (!ext_reset_n || $rose(ext_reset_n) |-> dflt)
      else $error("outputs off default under external reset");
   a_out_quiet: assert property ((drv == '1) [*8] |-> !alert_n_oe)
      else $error("alert with every pin driven");
   a_alert_up: assert property (
      (!alert_n_oe && $stable(pin) && ins) [*4] ##1 ($changed(pin) && ins) ##1
      ($stable(pin) && ins) [*4] |-> ##[0:400] alert_n_oe)
      else $error("pin edge gave no alert");
   a_alert_hold: assert property (
      (alert_n_oe && scl_i && $stable(pin) && $stable(drv)) [*6] |=>
      alert_n_oe || !ext_reset_n)
      else $error("alert dropped with pins unchanged");
   a_sda_scl_low: assert property (
      $changed(sda_oe) && ext_reset_n && $past(ext_reset_n) |-> !$past(scl_i, 3))
      else $error("data drive moved outside clock low");
   a_ack_width: assert property ($rose(sda_oe) |-> (sda_oe || !ext_reset_n) [*6])
      else $error("data drive shorter than a bit");
   c_alert: cover property ($rose(alert_n_oe));
   c_ack: cover property ($rose(sda_oe));
   c_dir: cover property ($changed(drv));
endmodule

bind i2c_io_expander_irq io_expander_properties #(.WIDTH(WIDTH)) props (
   .core_clk(core_clk), .rst(rst), .ext_reset_n(ext_reset_n), .scl_i(scl_i),
   .sda_o(sda_o), .sda_oe(sda_oe), .expander_pin_bus_i(expander_pin_bus_i),
   .expander_pin_bus_o(expander_pin_bus_o), .expander_pin_bus_oe(expander_pin_bus_oe),
   .alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe)
);
`default_nettype wire

//--- testbench/i2c_ctrl_model.sv
// bus controller model driving the expander's serial clock and data
`timescale 1ns/1ps
`default_nettype none
module i2c_ctrl_model (
   // clock and bus level
   input wire logic core_clk,
   input wire logic sda_line,
   // bus drive; data is only ever pulled low
   output logic scl,
   output logic sda_pull
);
   initial
   begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // 80 ns bit: data moves 2 cycles into clock low, sampled mid-high
   task automatic bit_io(input logic b, output logic s);
      sda_pull = !b;
      tick(2);
      scl = 1'b1;
      tick(2);
      s = sda_line;
      tick(2);
      scl = 1'b0;
      tick(2);
   endtask
   // entered from an idle bus or with clock low after an acknowledge
   task automatic start();
      sda_pull = 1'b0;
      tick(2);
      scl = 1'b1;
      tick(4);
      sda_pull = 1'b1;
      tick(4);
      scl = 1'b0;
      tick(2);
   endtask
   task automatic stop();
      sda_pull = 1'b1;
      tick(2);
      scl = 1'b1;
      tick(4);
      sda_pull = 1'b0;
      tick(4);
   endtask
   // msb first, ninth bit carries the acknowledge
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], s);
      bit_io(1'b1, s);
      ack = !s;
   endtask
   task automatic recv_byte(output logic [7:0] d, input logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, d[i]);
      bit_io(!ack, s);
   endtask
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// self-checking bench for the i2c io expander
`timescale 1ns/1ps
`default_nettype none
module tb_top import io_expander_pkg::*; ;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic ext_reset_n = 1'b1;
   logic addr_sel = 1'b0;
   logic [6:0] dev = TARGET_ADDR_LOW;
   logic [7:0] drv = 8'hA5;
   logic scl, pull, sda, sda_o, sda_oe, alert_n_o, alert_n_oe;
   logic [7:0] pin, pin_o, pin_oe;
   int fails = 0;
   int checked = 0;
   // released data line floats to its pull-up
   assign sda = !(pull || sda_oe);
   assign pin = (pin_oe & pin_o) | (~pin_oe & drv);
   i2c_io_expander_irq DUT (
      .core_clk(core_clk), .rst(rst), .ext_reset_n(ext_reset_n), .scl_i(scl),
      .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .addr_sel(addr_sel),
      .expander_pin_bus_i(pin), .expander_pin_bus_o(pin_o),
      .expander_pin_bus_oe(pin_oe), .alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe)
   );
   i2c_ctrl_model ctl (.core_clk(core_clk), .sda_line(sda), .scl(scl), .sda_pull(pull));
   initial
   begin
      forever #5 core_clk = ~core_clk;
   end
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic hdr(input logic [6:0] a, input logic r, output logic k);
      ctl.start();
      ctl.send_byte({a, r}, k);
   endtask
   task automatic wr(input logic [1:0] c, input logic [7:0] d);
      logic k;
      hdr(dev, 1'b0, k);
      ctl.send_byte({6'h00, c}, k);
      ctl.send_byte(d, k);
      check("write ack", {7'h00, k}, 8'h01);
      ctl.stop();
   endtask
   task automatic rd(input logic [1:0] c, input logic [7:0] exp);
      logic k;
      logic [7:0] d;
      hdr(dev, 1'b0, k);
      ctl.send_byte({6'h00, c}, k);
      hdr(dev, 1'b1, k);
      ctl.recv_byte(d, 1'b0);
      ctl.stop();
      check("read data", d, exp);
   endtask
   task automatic wait_alert(input logic exp);
      int n;
      n = 0;
      while (alert_n_oe !== exp && n < 500)
      begin
         @(negedge core_clk);
         n++;
      end
      check("alert", {7'h00, alert_n_oe}, {7'h00, exp});
      if (alert_n_oe !== exp)
         finish_test();
   endtask
   initial
   begin
      #500000;
      fails++;
      finish_test();
   end
   initial
   begin
      logic k;
      repeat (12) @(negedge core_clk);
      rst = 1'b0;
      repeat (6) @(negedge core_clk);
      check("dir", pin_oe, 8'h00);
      check("latch", pin_o, OUTPUT_RESET);
      rd(CMD_INPUT, 8'hA5);
      rd(CMD_OUTPUT, OUTPUT_RESET);
      rd(CMD_POLARITY, POLARITY_RESET);
      rd(CMD_CONFIG, CONFIG_RESET);
      wr(CMD_POLARITY, 8'h0F);
      rd(CMD_INPUT, 8'hAA);
      drv = 8'hA4;
      wait_alert(1'b1);
      drv = 8'hA5;
      wait_alert(1'b0);
      drv = 8'h25;
      wait_alert(1'b1);
      hdr(7'h22, 1'b1, k);
      check("foreign ack", {7'h00, k}, 8'h00);
      ctl.stop();
      wait_alert(1'b1);
      rd(CMD_INPUT, 8'h2A);
      wait_alert(1'b0);
      drv = 8'h24;
      wait_alert(1'b1);
      rd(CMD_INPUT, 8'h2B);
      wait_alert(1'b0);
      wr(CMD_OUTPUT, 8'h3C);
      wr(CMD_CONFIG, 8'h0F);
      check("latch", pin_o, 8'h3C);
      check("dir", pin_oe, 8'hF0);
      // output pins change level through the latch, input pins stay put
      wr(CMD_OUTPUT, 8'hC3);
      repeat (ALERT_VALID_CYC) @(negedge core_clk);
      check("alert", {7'h00, alert_n_oe}, 8'h00);
      wr(CMD_CONFIG, 8'h00);
      check("dir", pin_oe, 8'hFF);
      addr_sel = 1'b1;
      dev = TARGET_ADDR_HIGH;
      rd(CMD_OUTPUT, 8'hC3);
      hdr(TARGET_ADDR_LOW, 1'b0, k);
      check("low addr ack", {7'h00, k}, 8'h00);
      ctl.stop();
      // pulse past its minimum width, only between transfers
      ext_reset_n = 1'b0;
      repeat (5) @(negedge core_clk);
      ext_reset_n = 1'b1;
      repeat (6) @(negedge core_clk);
      check("dir", pin_oe, 8'h00);
      rd(CMD_OUTPUT, OUTPUT_RESET);
      finish_test();
   end
endmodule
`default_nettype wire
